// File: hdl/frsr_pkg.sv
// Constants and types for the startup, backup and restore block
// Contract
// - Flash-boot on: load flash into RAM, then cold
// - Cold start clears working memory; only start after reload
// - Flash-boot: hot start command still accepted, no reload
// - Flash-boot off: run from RAM, hot or cold
// - Save to flash halts unit operation meanwhile
// - Empty flash still overwrites RAM at startup
// - Corruption: status item FFFF, host word bit 04
// - Database error: only system block accessible
// - Battery low: blink indicator, set item, log 0330
package frsr_pkg;
  // Timing
  localparam int CLK_PERIOD_NS     = 20;
  localparam int BLINK_HALF_NS     = 500_000_000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
  // Sizes
  localparam int ADDR_W      = 6;
  localparam int MEM_AW      = 16;
  localparam int IMAGE_WORDS = 1024;
  localparam int BLOCK_W     = 10;
  localparam int IRQ_W       = 3;
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL       = 6'h00;
  localparam logic [5:0] OFF_CMD        = 6'h04;
  localparam logic [5:0] OFF_STATUS     = 6'h08;
  localparam logic [5:0] OFF_DB_ITEM    = 6'h0C;
  localparam logic [5:0] OFF_HOST_WORD  = 6'h10;
  localparam logic [5:0] OFF_BATT_ITEM  = 6'h14;
  localparam logic [5:0] OFF_LOG        = 6'h18;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h1C;
  localparam logic [5:0] OFF_IRQ_MASK   = 6'h20;
  // Field positions
  localparam int CTRL_HOT  = 0;
  localparam int CMD_SAVE  = 0;
  localparam int CMD_HOT   = 1;
  localparam int CMD_COLD  = 2;
  localparam int CMD_RINIT = 3;
  localparam int STS_RUN   = 0;
  localparam int STS_BOOT  = 1;
  localparam int STS_BUSY  = 2;
  localparam int STS_DBERR = 3;
  localparam int IRQ_DB    = 0;
  localparam int IRQ_BATT  = 1;
  localparam int IRQ_COPY  = 2;
  localparam int HOST_DB_BIT = 4;
  // Values
  localparam logic         RESET_STARTUP_HOT = 1'b1;
  localparam logic [15:0]  DB_ITEM_BAD  = 16'hFFFF;
  localparam logic [15:0]  DB_ITEM_OK   = 16'h0000;
  localparam logic [15:0]  LOG_BATTERY  = 16'h0330;
  localparam logic [9:0]   SYSTEM_BLOCK = 10'h000;
  localparam logic [1:0]   RESP_OKAY    = 2'h0;
  localparam logic [1:0]   RESP_DECERR  = 2'h3;
  // Startup sequencer states
  typedef enum logic [1:0] {ST_BOOT, ST_LOAD, ST_RUN, ST_SAVE} start_state_t;
endpackage

// File: hdl/copy_ctl_if.sv
// Request bundle between the startup sequencer and the copy engine
`timescale 1ns/1ps
interface copy_ctl_if;
  logic start;    // One-cycle request for a whole-image copy
  logic to_flash; // Direction: RAM into flash when high
  logic busy;     // Copy in progress
  logic done;     // One-cycle pulse at the end of a copy
  modport engine    (input start, input to_flash, output busy, output done);
  modport sequencer (output start, output to_flash, input busy, input done);
endinterface // copy_ctl_if

// File: hdl/image_copy_engine.sv
// Word-by-word copier between flash and battery-backed RAM
`timescale 1ns/1ps
module image_copy_engine #(
  parameter int WORDS = frsr_pkg::IMAGE_WORDS,
  parameter int AW    = frsr_pkg::MEM_AW
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  copy_ctl_if.engine         ctl,
  output logic               flash_req,
  output logic               flash_we,
  output logic [AW-1:0]      flash_addr,
  output logic [31:0]        flash_wdata,
  input  wire logic [31:0]   flash_rdata,
  input  wire logic          flash_ack,
  output logic               ram_req,
  output logic               ram_we,
  output logic [AW-1:0]      ram_addr,
  output logic [31:0]        ram_wdata,
  input  wire logic [31:0]   ram_rdata,
  input  wire logic          ram_ack
);
  typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} phase_t;
  typedef struct packed {
    phase_t          ph;       // Copy phase
    logic            to_flash; // Latched direction
    logic [AW-1:0]   addr;     // Word index, same on both sides
    logic [31:0]     data;     // Word in flight
    logic            done;     // End pulse
  } eng_t;
  eng_t        q;
  eng_t        next_q;
  logic        src_ack;
  logic [31:0] src_rdata;
  logic        dst_ack;

  // Source and sink follow the latched direction
  assign src_ack   = q.to_flash ? ram_ack : flash_ack;
  assign src_rdata = q.to_flash ? ram_rdata : flash_rdata;
  assign dst_ack   = q.to_flash ? flash_ack : ram_ack;

  // Every word is copied; no check for a blank image, so a load always overwrites RAM
  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    case (q.ph)
      PH_IDLE: begin
        if (ctl.start) begin
          next_q.ph       = PH_READ;
          next_q.to_flash = ctl.to_flash;
          next_q.addr     = '0;
        end
      end
      PH_READ: begin
        if (src_ack) begin
          next_q.data = src_rdata;
          next_q.ph   = PH_WRITE;
        end
      end
      PH_WRITE: begin
        if (dst_ack && q.addr == AW'(WORDS - 1)) begin
          next_q.ph   = PH_IDLE;
          next_q.done = 1'b1;
        end else if (dst_ack) begin
          next_q.addr = q.addr + 1'b1;
          next_q.ph   = PH_READ;
        end
      end
      default: next_q.ph = PH_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= next_q;
  end

  // Requests held until acknowledged
  assign flash_req   = (q.ph == PH_READ && !q.to_flash) || (q.ph == PH_WRITE && q.to_flash);
  assign ram_req     = (q.ph == PH_READ && q.to_flash) || (q.ph == PH_WRITE && !q.to_flash);
  assign flash_we    = q.to_flash;
  assign ram_we      = !q.to_flash;
  assign flash_addr  = q.addr;
  assign ram_addr    = q.addr;
  assign flash_wdata = q.data;
  assign ram_wdata   = q.data;
  assign ctl.busy    = q.ph != PH_IDLE;
  assign ctl.done    = q.done;
endmodule // image_copy_engine

// File: hdl/blink_divider.sv
// Half-period divider that blinks a lamp while enabled
`timescale 1ns/1ps
module blink_divider #(
  parameter int HALF_CYCLES = frsr_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  output logic      blink
);
  typedef struct packed {
    logic [31:0] count; // Cycles into the half period
    logic        lamp;  // Lamp level
  } blink_t;
  blink_t q;
  blink_t next_q;

  // Lamp dark and counter cleared whenever disabled
  always_comb begin
    next_q = q;
    if (!enable) begin
      next_q = '0;
    end else if (q.count == 32'(HALF_CYCLES - 1)) begin
      next_q.count = '0;
      next_q.lamp  = !q.lamp;
    end else begin
      next_q.count = q.count + 32'h1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= next_q;
  end

  assign blink = q.lamp;
endmodule // blink_divider

// File: hdl/flash_ram_startup_restore.sv
// Startup sequencer, flash backup, database and battery supervision
`timescale 1ns/1ps
module flash_ram_startup_restore #(
  parameter int BLINK_HALF_CYCLES = frsr_pkg::BLINK_HALF_CYCLES,
  parameter int IMAGE_WORDS       = frsr_pkg::IMAGE_WORDS,
  parameter int MEM_AW            = frsr_pkg::MEM_AW
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite slave
  input  wire logic [frsr_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [frsr_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // Straps and monitors
  input  wire logic                         flash_boot_switch,
  input  wire logic                         battery_low,
  input  wire logic                         db_corrupt,
  // Function block access arbitration
  input  wire logic                         fb_req,
  input  wire logic [frsr_pkg::BLOCK_W-1:0] fb_block,
  output logic                              fb_grant,
  output logic                              fb_refuse,
  // Operation control
  output logic                              unit_run,
  output logic                              cold_start,
  output logic                              hot_start,
  // Status items and indicators
  output logic [15:0]                       database_status_item,
  output logic [15:0]                       host_status_word,
  output logic                              battery_error_item,
  output logic                              battery_error_indicator,
  output logic                              irq,
  // Flash memory port
  output logic                              flash_req,
  output logic                              flash_we,
  output logic [MEM_AW-1:0]                 flash_addr,
  output logic [31:0]                       flash_wdata,
  input  wire logic [31:0]                  flash_rdata,
  input  wire logic                         flash_ack,
  // Battery-backed RAM port
  output logic                              ram_req,
  output logic                              ram_we,
  output logic [MEM_AW-1:0]                 ram_addr,
  output logic [31:0]                       ram_wdata,
  input  wire logic [31:0]                  ram_rdata,
  input  wire logic                         ram_ack
);
  typedef struct packed {
    frsr_pkg::start_state_t      st;          // Sequencer state
    logic                        boot_flash;  // Strap caught at startup
    logic                        startup_hot; // Start type without flash-boot
    logic                        db_error;    // Database corrupted
    logic                        batt_item;   // Battery error item
    logic                        batt_prev;   // Previous battery level
    logic [15:0]                 log_code;    // Last error log code
    logic [7:0]                  log_count;   // Log entries stored
    logic [frsr_pkg::IRQ_W-1:0]  irq_status;  // Sticky events
    logic [frsr_pkg::IRQ_W-1:0]  irq_mask;    // Event enables
    logic                        aw_full;     // Write address held
    logic [frsr_pkg::ADDR_W-1:0] aw_addr;
    logic                        w_full;      // Write data held
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic                        copy_start;  // Pulse to the engine
    logic                        copy_to_flash;
    logic                        cold_pulse;
    logic                        hot_pulse;
  } top_t;

  top_t                        q;
  top_t                        next_q;
  logic                        wr_fire;     // Both write halves present
  logic [31:0]                 wmask;       // Byte lanes as bit mask
  logic [31:0]                 wd;          // Masked write data
  logic [31:0]                 rd;          // Read word being built
  logic [1:0]                  rd_resp;
  logic                        cmd_save;
  logic                        cmd_hot;
  logic                        cmd_cold;
  logic                        cmd_rinit;
  logic [frsr_pkg::IRQ_W-1:0]  irq_clr;
  logic [frsr_pkg::IRQ_W-1:0]  irq_set;
  logic                        batt_event;

  copy_ctl_if copy_ctl ();

  // Whole-image copier
  image_copy_engine #(
    .WORDS (IMAGE_WORDS),
    .AW    (MEM_AW)
  ) u_copy (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ctl         (copy_ctl.engine),
    .flash_req   (flash_req),
    .flash_we    (flash_we),
    .flash_addr  (flash_addr),
    .flash_wdata (flash_wdata),
    .flash_rdata (flash_rdata),
    .flash_ack   (flash_ack),
    .ram_req     (ram_req),
    .ram_we      (ram_we),
    .ram_addr    (ram_addr),
    .ram_wdata   (ram_wdata),
    .ram_rdata   (ram_rdata),
    .ram_ack     (ram_ack)
  );

  // Battery lamp blinks while the item is set
  blink_divider #(
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_blink (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (q.batt_item),
    .blink   (battery_error_indicator)
  );

  assign copy_ctl.start    = q.copy_start;
  assign copy_ctl.to_flash = q.copy_to_flash;

  // Write byte lanes
  assign wmask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
  assign wd    = q.w_data & wmask;
  assign wr_fire = q.aw_full && q.w_full && !q.bvalid;

  // Read word decode
  always_comb begin
    rd      = '0;
    rd_resp = frsr_pkg::RESP_OKAY;
    case (araddr)
      frsr_pkg::OFF_CTRL:       rd[frsr_pkg::CTRL_HOT] = q.startup_hot;
      frsr_pkg::OFF_CMD:        rd = '0; // Commands read back as zero
      frsr_pkg::OFF_STATUS: begin
        rd[frsr_pkg::STS_RUN]   = q.st == frsr_pkg::ST_RUN;
        rd[frsr_pkg::STS_BOOT]  = q.boot_flash;
        rd[frsr_pkg::STS_BUSY]  = copy_ctl.busy;
        rd[frsr_pkg::STS_DBERR] = q.db_error;
      end
      frsr_pkg::OFF_DB_ITEM:    rd[15:0] = database_status_item;
      frsr_pkg::OFF_HOST_WORD:  rd[15:0] = host_status_word;
      frsr_pkg::OFF_BATT_ITEM:  rd[0] = q.batt_item;
      frsr_pkg::OFF_LOG:        rd = {8'h00, q.log_count, q.log_code};
      frsr_pkg::OFF_IRQ_STATUS: rd[frsr_pkg::IRQ_W-1:0] = q.irq_status;
      frsr_pkg::OFF_IRQ_MASK:   rd[frsr_pkg::IRQ_W-1:0] = q.irq_mask;
      default:                  rd_resp = frsr_pkg::RESP_DECERR; // Unmapped
    endcase
  end

  // Write decode: command pulses and clears
  always_comb begin
    cmd_save  = 1'b0;
    cmd_hot   = 1'b0;
    cmd_cold  = 1'b0;
    cmd_rinit = 1'b0;
    irq_clr   = '0;
    if (wr_fire && q.aw_addr == frsr_pkg::OFF_CMD) begin
      cmd_save  = wd[frsr_pkg::CMD_SAVE];
      cmd_hot   = wd[frsr_pkg::CMD_HOT];
      cmd_cold  = wd[frsr_pkg::CMD_COLD];
      cmd_rinit = wd[frsr_pkg::CMD_RINIT];
    end
    if (wr_fire && q.aw_addr == frsr_pkg::OFF_IRQ_STATUS) begin
      irq_clr = wd[frsr_pkg::IRQ_W-1:0];
    end
  end

  // Hardware events
  assign batt_event = battery_low && !q.batt_prev;
  always_comb begin
    irq_set                     = '0;
    irq_set[frsr_pkg::IRQ_DB]   = db_corrupt;
    irq_set[frsr_pkg::IRQ_BATT] = batt_event;
    irq_set[frsr_pkg::IRQ_COPY] = copy_ctl.done;
  end

  // Next-state logic for the whole block
  always_comb begin
    next_q            = q;
    next_q.copy_start = 1'b0;
    next_q.cold_pulse = 1'b0;
    next_q.hot_pulse  = 1'b0;

    // Write address and data channels, taken in either order
    if (awvalid && !q.aw_full) begin
      next_q.aw_full = 1'b1;
      next_q.aw_addr = awaddr;
    end
    if (wvalid && !q.w_full) begin
      next_q.w_full = 1'b1;
      next_q.w_data = wdata;
      next_q.w_strb = wstrb;
    end
    if (wr_fire) begin
      next_q.aw_full = 1'b0;
      next_q.w_full  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = frsr_pkg::RESP_OKAY;
      case (q.aw_addr)
        frsr_pkg::OFF_CTRL: begin
          if (q.w_strb[0]) next_q.startup_hot = q.w_data[frsr_pkg::CTRL_HOT];
        end
        frsr_pkg::OFF_IRQ_MASK: begin
          if (q.w_strb[0]) next_q.irq_mask = q.w_data[frsr_pkg::IRQ_W-1:0];
        end
        frsr_pkg::OFF_CMD,
        frsr_pkg::OFF_IRQ_STATUS: next_q.bresp = frsr_pkg::RESP_OKAY;
        // Read-only items accept and ignore writes
        frsr_pkg::OFF_STATUS,
        frsr_pkg::OFF_DB_ITEM,
        frsr_pkg::OFF_HOST_WORD,
        frsr_pkg::OFF_BATT_ITEM,
        frsr_pkg::OFF_LOG: next_q.bresp = frsr_pkg::RESP_OKAY;
        default: next_q.bresp = frsr_pkg::RESP_DECERR;
      endcase
    end
    if (q.bvalid && bready) next_q.bvalid = 1'b0;

    // Read channel: one outstanding read
    if (arvalid && !q.rvalid) begin
      next_q.rvalid = 1'b1;
      next_q.rdata  = rd;
      next_q.rresp  = rd_resp;
    end else if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end

    // Sticky events; a set in the clearing cycle wins
    next_q.irq_status = (q.irq_status & ~irq_clr) | irq_set;

    // Database error held until the reinit command
    next_q.db_error = (q.db_error && !cmd_rinit) || db_corrupt;

    // Battery supervision and error log
    next_q.batt_prev = battery_low;
    next_q.batt_item = battery_low;
    if (batt_event) begin
      next_q.log_code  = frsr_pkg::LOG_BATTERY;
      next_q.log_count = q.log_count + 8'h01;
    end

    // Startup and backup sequencer
    case (q.st)
      frsr_pkg::ST_BOOT: begin
        // Strap is caught here, after reset has released
        next_q.boot_flash = flash_boot_switch;
        if (flash_boot_switch) begin
          next_q.copy_start    = 1'b1;
          next_q.copy_to_flash = 1'b0;
          next_q.st            = frsr_pkg::ST_LOAD;
        end else begin
          // Existing RAM kept; start type from control
          next_q.hot_pulse  = q.startup_hot;
          next_q.cold_pulse = !q.startup_hot;
          next_q.st         = frsr_pkg::ST_RUN;
        end
      end
      frsr_pkg::ST_LOAD: begin
        // After a reload only a cold start is possible
        if (copy_ctl.done) begin
          next_q.cold_pulse = 1'b1;
          next_q.st         = frsr_pkg::ST_RUN;
        end
      end
      frsr_pkg::ST_RUN: begin
        // Save has priority over restart commands
        if (cmd_save) begin
          next_q.copy_start    = 1'b1;
          next_q.copy_to_flash = 1'b1;
          next_q.st            = frsr_pkg::ST_SAVE;
        end else if (cmd_cold) begin
          next_q.cold_pulse = 1'b1;
        end else if (cmd_hot) begin
          // No reload, even in flash-boot mode
          next_q.hot_pulse = 1'b1;
        end
      end
      frsr_pkg::ST_SAVE: begin
        // Operation resumes with its memory intact
        if (copy_ctl.done) begin
          next_q.hot_pulse = 1'b1;
          next_q.st        = frsr_pkg::ST_RUN;
        end
      end
      default: next_q.st = frsr_pkg::ST_BOOT;
    endcase
  end

  // State register; reset values are constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q             <= '0;
      q.st          <= frsr_pkg::ST_BOOT;
      q.startup_hot <= frsr_pkg::RESET_STARTUP_HOT;
    end else begin
      q <= next_q;
    end
  end

  // Bus outputs
  assign awready = !q.aw_full;
  assign wready  = !q.w_full;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  // Operation control; halted while a copy runs
  assign unit_run   = q.st == frsr_pkg::ST_RUN;
  assign cold_start = q.cold_pulse;
  assign hot_start  = q.hot_pulse;

  // Status items
  assign database_status_item = q.db_error ? frsr_pkg::DB_ITEM_BAD
                                           : frsr_pkg::DB_ITEM_OK;
  assign host_status_word     = 16'(q.db_error) << frsr_pkg::HOST_DB_BIT;
  assign battery_error_item   = q.batt_item;

  // Lockout: only the system block while the database is bad
  assign fb_grant  = fb_req && (!q.db_error || fb_block == frsr_pkg::SYSTEM_BLOCK);
  assign fb_refuse = fb_req && !fb_grant;

  // Level interrupt from unmasked sticky events
  assign irq = |(q.irq_status & q.irq_mask);
endmodule // flash_ram_startup_restore

// File: test/word_mem_model.sv
// Behavioural word memory standing in for flash or backed RAM
`timescale 1ns/1ps
module word_mem_model #(
  parameter logic [31:0] FILL  = 32'h0000_0000, // Base of preset contents
  parameter int          STALL = 0              // Wait cycles before ack
) (
  input  wire logic        aclk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata,
  output logic             ack
);
  logic [31:0] mem [16]; // Only low words are used
  int          wait_n;   // Cycles spent on this request
  // Distinct presets so a copy shows as changed words
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = FILL + 32'(i);
    ack = 1'b0;
    rdata = 32'h0000_0000;
    wait_n = 0;
  end
  // One ack per word; data scrambles outside ack so stale reads show
  always @(posedge aclk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack && wait_n < STALL) wait_n <= wait_n + 1;
    else if (req && !ack) begin
      ack <= 1'b1;
      wait_n <= 0;
      rdata <= mem[addr[3:0]];
      if (we) mem[addr[3:0]] <= wdata;
    end
  end
endmodule // word_mem_model

// File: test/frsr_assertions.sv
// Port-level checks for the startup, backup and restore block
`timescale 1ns/1ps
module frsr_checker (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic                         db_corrupt,
  input wire logic                         fb_req,
  input wire logic [frsr_pkg::BLOCK_W-1:0] fb_block,
  input wire logic                         fb_grant,
  input wire logic                         fb_refuse,
  input wire logic [15:0]                  database_status_item,
  input wire logic [15:0]                  host_status_word,
  input wire logic                         flash_req,
  input wire logic                         ram_req,
  input wire logic                         unit_run,
  input wire logic                         cold_start,
  input wire logic                         battery_low,
  input wire logic                         battery_error_item,
  input wire logic                         battery_error_indicator,
  input wire logic                         bvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_DB_SET: assert property (db_corrupt |=> database_status_item == 16'hFFFF
    && host_status_word == 16'h0010) else $error("db error not flagged");
  AST_FB_LOCK: assert property (fb_req && fb_block != 10'h000 && host_status_word[4]
    |-> fb_refuse && !fb_grant) else $error("locked block granted");
  AST_FB_SYS: assert property (fb_req && fb_block == 10'h000 |-> fb_grant && !fb_refuse)
    else $error("system block refused");
  AST_DB_HOLD: assert property ($fell(host_status_word[4]) |-> bvalid)
    else $error("db error cleared without command");
  AST_COPY_HALT: assert property (flash_req || ram_req |-> !unit_run)
    else $error("running during copy");
  AST_COLD_RUN: assert property (cold_start |-> unit_run ##1 !cold_start)
    else $error("cold start pulse wrong");
  AST_BATT_ITEM: assert property (battery_low ##1 battery_low |-> battery_error_item)
    else $error("battery item not set");
  AST_BLINK_OFF: assert property ((!battery_error_item) [*2] |-> !battery_error_indicator)
    else $error("indicator lit without error");
  // Main scenarios reached
  cover property (db_corrupt);
  cover property (cold_start);
  cover property ($rose(battery_error_indicator));
endmodule // frsr_checker
bind flash_ram_startup_restore frsr_checker frsr_checker_i (.*);

// File: test/tb_flash_ram_startup_restore.sv
// Directed bench for the startup, backup and restore block
`timescale 1ns/1ps
module tb_flash_ram_startup_restore;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, flash_boot_switch = 1'b0, battery_low = 1'b0;
  logic db_corrupt = 1'b0, fb_req = 1'b0, prev;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, flash_rdata, flash_wdata, ram_rdata, ram_wdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [9:0] fb_block = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, fb_grant, fb_refuse, unit_run, irq;
  logic cold_start, hot_start, battery_error_item, battery_error_indicator;
  logic flash_req, flash_we, flash_ack, ram_req, ram_we, ram_ack;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] database_status_item, host_status_word, flash_addr, ram_addr;
  int n_errors = 0, checked = 0, n_cold = 0, n_hot = 0, n_fetch = 0, tg = 0;
  // Short counts keep the run brief
  flash_ram_startup_restore #(.BLINK_HALF_CYCLES(4), .IMAGE_WORDS(4))
    flash_ram_startup_restore_i (.*);
  // Slow flash, prompt RAM
  word_mem_model #(.FILL(32'hA000_0000), .STALL(2)) flash_mem (.aclk(aclk), .req(flash_req),
    .we(flash_we), .addr(flash_addr), .wdata(flash_wdata), .rdata(flash_rdata), .ack(flash_ack));
  word_mem_model #(.FILL(32'h1000_0000)) ram_mem (.aclk(aclk), .req(ram_req),
    .we(ram_we), .addr(ram_addr), .wdata(ram_wdata), .rdata(ram_rdata), .ack(ram_ack));
  always #10 aclk = ~aclk;
  // Tally pulses mid-cycle, race-free
  always @(negedge aclk) begin
    if (cold_start === 1'b1) n_cold++;
    if (hot_start === 1'b1) n_hot++;
    if (flash_req === 1'b1 && flash_ack === 1'b1 && flash_we === 1'b0) n_fetch++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rr = rresp;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    axr(a);
    chk(rd, exp);
  endtask
  task automatic wait_run;
    do @(posedge aclk); while (unit_run !== 1'b1);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run;
    chk(n_hot, 1);
    chk(n_fetch, 0);
    rchk(frsr_pkg::OFF_CTRL, 32'h1);
    axw(frsr_pkg::OFF_CMD, 32'h1);
    chk(unit_run, 1'b0);
    wait_run;
    chk(flash_mem.mem[3], 32'h1000_0003);
    axw(frsr_pkg::OFF_IRQ_MASK, 32'h7);
    rchk(frsr_pkg::OFF_IRQ_STATUS, 32'h4);
    chk(irq, 1'b1);
    axw(frsr_pkg::OFF_IRQ_STATUS, 32'h4);
    rchk(frsr_pkg::OFF_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    axw(frsr_pkg::OFF_CMD, 32'h4);
    rchk(frsr_pkg::OFF_STATUS, 32'h1);
    chk(n_cold, 1);
    db_corrupt <= 1'b1;
    @(posedge aclk);
    db_corrupt <= 1'b0;
    fb_req <= 1'b1;
    fb_block <= 10'h005;
    @(posedge aclk);
    chk(database_status_item, 32'hFFFF);
    chk(host_status_word, 32'h10);
    chk({fb_grant, fb_refuse}, 2'b01);
    fb_block <= 10'h000;
    @(posedge aclk);
    chk({fb_grant, fb_refuse}, 2'b10);
    fb_block <= 10'h3FF;
    rchk(frsr_pkg::OFF_STATUS, 32'h9);
    axw(frsr_pkg::OFF_CMD, 32'h8);
    rchk(frsr_pkg::OFF_DB_ITEM, 32'h0);
    chk({host_status_word, fb_grant}, 17'h1);
    battery_low <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(battery_error_item, 1'b1);
    rchk(frsr_pkg::OFF_LOG, 32'h0001_0330);
    prev = battery_error_indicator;
    // Half period of four cycles gives four changes in sixteen
    repeat (16) begin
      @(posedge aclk);
      if (battery_error_indicator !== prev) tg++;
      prev = battery_error_indicator;
    end
    chk(tg, 4);
    battery_low <= 1'b0;
    axr(6'h3C);
    chk(rr, frsr_pkg::RESP_DECERR);
    @(posedge aclk);
    chk({battery_error_item, battery_error_indicator}, 2'b00);
    // Flash-boot restart must overwrite the altered RAM word
    ram_mem.mem[2] = 32'h5555_5555;
    flash_boot_switch <= 1'b1;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run;
    chk(n_cold, 2);
    chk(n_fetch, 4);
    chk(ram_mem.mem[2], 32'h1000_0002);
    axw(frsr_pkg::OFF_CMD, 32'h2);
    rchk(frsr_pkg::OFF_STATUS, 32'h3);
    chk(n_hot, 3);
    chk(n_fetch, 4);
    complete_run;
  end
endmodule // tb_flash_ram_startup_restore
